// ### rtl/flash_status_pkg.sv
// constants for the flash status polling controller
// Behaviour
// - host reads status twice; unchanged toggle bit means operation complete
// - toggling with error bit high: recheck, still toggling means fail, send reset
// - host resuming polling after other work restarts from the double read
// - after an error the host issues reset; device returns to array reads
// - host checks window bit before and after each extra sector erase command; this poller sends no erase and only reports the bit in last_status
// - host may skip window check if commands come under 50 us apart
// - status reads use busy bank address and a valid sector address
package flash_status_pkg;
    // status bit positions on the data bus
    localparam int POLLING_STATUS_BIT = 7;
    localparam int TOGGLING_STATUS_BIT = 6;
    localparam int TIME_LIMIT_ERROR_BIT = 5;
    localparam int ERASE_WINDOW_BIT = 3;
    localparam int PER_SECTOR_TOGGLE_BIT = 2;
    // bus widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    // command cycle values
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // strobe timing in clock cycles of 10 ns
    localparam int CLOCK_NS = 10;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYCLES = (STROBE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int GAP_NS = 40;
    localparam int GAP_CYCLES = (GAP_NS + CLOCK_NS - 1) / CLOCK_NS;
    // window skip spacing, 50 us as a longest time
    localparam int WINDOW_SKIP_US = 50;
    localparam int WINDOW_SKIP_CYCLES = WINDOW_SKIP_US * 1000 / CLOCK_NS;
    // poll result codes
    typedef enum logic [1:0] {
        RESULT_NONE,
        RESULT_DONE,
        RESULT_FAIL
    } result_t;
endpackage : flash_status_pkg

// ### rtl/flash_status_poller.sv
// host side toggle-bit poller and reset issuer for a dual-bank flash
`timescale 1ns/1ps
`default_nettype none
module flash_status_poller #(
    parameter int STROBE_LEN = flash_status_pkg::STROBE_CYCLES,
    parameter int GAP_LEN = flash_status_pkg::GAP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    // user side
    input wire logic start,
    input wire logic [flash_status_pkg::ADDR_W-1:0] status_addr,
    input wire logic abort,
    output logic busy,
    output logic done,
    output flash_status_pkg::result_t result,
    output logic [flash_status_pkg::DATA_W-1:0] last_status,
    output logic ready_seen,
    // flash pins
    output logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_strobe_n,
    input wire logic [flash_status_pkg::DATA_W-1:0] flash_data_in,
    output logic [flash_status_pkg::DATA_W-1:0] flash_data_out,
    output logic flash_data_oe,
    input wire logic ready_busy_n_output
);
    import flash_status_pkg::*;

    typedef enum logic [3:0] {
        IDLE, READ_A, GAP_A, READ_B, CHECK, GAP_B, GAP_C, READ_C, GAP_D, READ_D, RECHECK, WRITE_RST, FINISH
    } state_t;

    state_t state_q;
    logic [7:0] count_q;
    logic [DATA_W-1:0] first_q;
    logic [DATA_W-1:0] sample_q;
    logic [ADDR_W-1:0] addr_q;
    logic fail_q;

    // toggle test between two status samples
    function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        toggled = a[TOGGLING_STATUS_BIT] ^ b[TOGGLING_STATUS_BIT];
    endfunction : toggled

    // time-limit error flag of a status sample
    function automatic logic error_seen(input logic [DATA_W-1:0] s);
        error_seen = s[TIME_LIMIT_ERROR_BIT];
    endfunction : error_seen

    wire strobe_end = (count_q == 8'(STROBE_LEN - 1));
    wire gap_end = (count_q == 8'(GAP_LEN - 1));
    wire read_state = (state_q == READ_A) || (state_q == READ_B) || (state_q == READ_C) || (state_q == READ_D);

    // poll sequencer; an abort drops the poll except during the reset write, a later start restarts at the double read
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= IDLE;
            count_q <= 8'h00;
        end else if (abort && state_q != IDLE && state_q != WRITE_RST) begin
            state_q <= IDLE;
            count_q <= 8'h00;
        end else begin
            unique case (state_q)
                IDLE: begin
                    count_q <= 8'h00;
                    if (start) begin
                        state_q <= READ_A;
                    end
                end
                READ_A, READ_B, READ_C, READ_D, WRITE_RST: begin
                    if (strobe_end) begin
                        count_q <= 8'h00;
                        unique case (state_q)
                            READ_A: state_q <= GAP_A;
                            READ_B: state_q <= CHECK;
                            READ_C: state_q <= GAP_D;
                            READ_D: state_q <= RECHECK;
                            default: state_q <= FINISH;
                        endcase
                    end else begin
                        count_q <= count_q + 8'h01;
                    end
                end
                GAP_A, GAP_B, GAP_C, GAP_D: begin
                    if (gap_end) begin
                        count_q <= 8'h00;
                        unique case (state_q)
                            GAP_A: state_q <= READ_B;
                            GAP_B: state_q <= READ_A;
                            GAP_C: state_q <= READ_C;
                            default: state_q <= READ_D;
                        endcase
                    end else begin
                        count_q <= count_q + 8'h01;
                    end
                end
                CHECK: begin
                    // double read done; steady bit means complete
                    if (!toggled(first_q, sample_q)) begin
                        state_q <= FINISH;
                    end else if (error_seen(sample_q)) begin
                        state_q <= GAP_C;
                    end else begin
                        state_q <= GAP_B; // keep polling with a fresh double read
                    end
                end
                RECHECK: begin
                    if (toggled(first_q, sample_q)) begin
                        state_q <= WRITE_RST;
                    end else begin
                        state_q <= FINISH;
                    end
                end
                FINISH: state_q <= IDLE;
                default: state_q <= IDLE;
            endcase
        end
    end

    // failure flag, set when the recheck pair still toggles
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fail_q <= 1'b0;
        end else if (state_q == IDLE && start) begin
            fail_q <= 1'b0;
        end else if (state_q == RECHECK && !abort && toggled(first_q, sample_q)) begin
            fail_q <= 1'b1;
        end
    end

    // first read of a pair, taken on the last cycle of its strobe
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            first_q <= 8'h00;
        end else if (strobe_end && (state_q == READ_A || state_q == READ_C)) begin
            first_q <= flash_data_in;
        end
    end

    // second read of a pair, the one the decision looks at
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sample_q <= 8'h00;
        end else if (strobe_end && (state_q == READ_B || state_q == READ_D)) begin
            sample_q <= flash_data_in;
        end
    end

    // address latch: busy bank and valid sector given by the user
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            addr_q <= '0;
        end else if (state_q == IDLE && start) begin
            addr_q <= status_addr;
        end
    end

    // address pins follow the latched status address
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flash_addr <= '0;
        end else begin
            flash_addr <= addr_q;
        end
    end

    // select and strobes; each read framed on its own so the device sees successive reads
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            chip_select_n <= !(read_state || state_q == WRITE_RST);
            output_enable_n <= !read_state || strobe_end;
            write_strobe_n <= !(state_q == WRITE_RST) || strobe_end;
        end
    end

    // data pins driven only while the reset command is written
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flash_data_out <= 8'h00;
            flash_data_oe <= 1'b0;
        end else begin
            flash_data_out <= (state_q == WRITE_RST) ? CMD_RESET : 8'h00;
            flash_data_oe <= (state_q == WRITE_RST);
        end
    end

    // busy level and one-cycle done pulse
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= (state_q != IDLE);
            done <= (state_q == FINISH);
        end
    end

    // poll outcome, held until the next start
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            result <= RESULT_NONE;
        end else if (state_q == FINISH) begin
            result <= fail_q ? RESULT_FAIL : RESULT_DONE;
        end else if (state_q == IDLE && start) begin
            result <= RESULT_NONE;
        end
    end

    // latest status byte, window bit included, and the pin's ready level for the user
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            last_status <= 8'h00;
            ready_seen <= 1'b0;
        end else begin
            last_status <= sample_q;
            ready_seen <= ready_busy_n_output;
        end
    end
endmodule : flash_status_poller
`default_nettype wire

// ### dv/flash_status_poller_props.sv
// assertions on the status poller ports
`timescale 1ns/1ps
`default_nettype none
module flash_status_poller_props (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic done,
    input var flash_status_pkg::result_t result,
    input wire logic [7:0] last_status,
    input wire logic [21:0] flash_addr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] flash_data_out,
    input wire logic flash_data_oe
);
    import flash_status_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_done_coded: assert property (done |-> result != RESULT_NONE) else $error("done without result");
    a_read_framed: assert property (!output_enable_n |-> !chip_select_n) else $error("read not selected");
    a_write_alone: assert property (!write_strobe_n |-> output_enable_n && flash_data_oe &&
        flash_data_out == CMD_RESET) else $error("bad reset write");
    a_write_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*7] ##1 write_strobe_n)
        else $error("write strobe length wrong");
    a_fail_follows: assert property ($fell(write_strobe_n) |-> ##[1:20] done && result == RESULT_FAIL)
        else $error("no fail after reset write");
    a_fail_error: assert property (done && result == RESULT_FAIL |-> last_status[TIME_LIMIT_ERROR_BIT])
        else $error("fail without error bit");
    a_addr_stable: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr))
        else $error("address moved in poll");
    c_done: cover property (done && result == RESULT_DONE);
    c_fail: cover property (done && result == RESULT_FAIL);
    c_write: cover property ($fell(write_strobe_n));
endmodule : flash_status_poller_props
bind flash_status_poller flash_status_poller_props chk (.clock(clock), .reset_n(reset_n), .done(done),
    .result(result), .last_status(last_status), .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n), .flash_data_out(flash_data_out),
    .flash_data_oe(flash_data_oe));
`default_nettype wire

// ### dv/flash_device_model.sv
// behavioural flash device answering status reads
`timescale 1ns/1ps
`default_nettype none
module flash_device_model (
    input wire logic clock,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] host_data,
    input wire logic host_oe,
    input wire logic load,
    input wire logic [7:0] load_reads,
    input wire logic load_err,
    output logic [7:0] data,
    output logic ready_busy_n_output,
    output logic [7:0] resets_q
);
    import flash_status_pkg::*;
    logic [7:0] run_q = 8'h00;
    logic [7:0] pat_q = 8'h00;
    logic err_q = 1'b0, tog_q = 1'b0, sec_q = 1'b0, oe_q = 1'b1, we_q = 1'b1;
    wire running = (run_q != 8'h00);
    initial resets_q = 8'h00;
    // one inversion per finished read while the operation runs
    always @(posedge clock) begin
        oe_q <= output_enable_n;
        we_q <= write_strobe_n;
        pat_q <= pat_q + 8'h5B;
        if (load) begin
            run_q <= load_reads;
            err_q <= load_err;
        end else if (!write_strobe_n && we_q && host_oe && host_data == CMD_RESET) begin
            run_q <= 8'h00;
            err_q <= 1'b0;
            resets_q <= resets_q + 8'h01;
        end else if (!oe_q && output_enable_n && running) begin
            run_q <= run_q - 8'h01;
            tog_q <= ~tog_q;
            sec_q <= ~sec_q;
        end
    end
    // selected read gives polling, toggle, error, window and per-sector bits, else a moving pattern
    assign data = (!chip_select_n && !output_enable_n) ?
        {!running, tog_q, err_q, 1'b0, running, sec_q, 2'b00} : pat_q;
    assign ready_busy_n_output = (run_q == 8'h00);
endmodule : flash_device_model
`default_nettype wire

// ### dv/test_flash_status_poller.sv
// testbench for the status poller against a device model
`timescale 1ns/1ps
`default_nettype none
module test_flash_status_poller;
    import flash_status_pkg::*;
    logic clock = 0, reset_n = 0, start = 0, abort = 0, load = 0, load_err = 0;
    logic [7:0] load_reads = 8'h00, resets, din, dout, last_status;
    logic [21:0] status_addr = 22'h000000, flash_addr;
    logic busy, done, ready_seen, cs_n, oe_n, we_n, data_oe, rb_n;
    result_t result;
    int n_errors = 0, check_count = 0;
    initial forever #5 clock = ~clock;
    flash_status_poller dut (.clock(clock), .reset_n(reset_n), .start(start), .status_addr(status_addr),
        .abort(abort), .busy(busy), .done(done), .result(result), .last_status(last_status),
        .ready_seen(ready_seen), .flash_addr(flash_addr), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .flash_data_in(din), .flash_data_out(dout), .flash_data_oe(data_oe),
        .ready_busy_n_output(rb_n));
    flash_device_model dev (.clock(clock), .chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
        .host_data(dout), .host_oe(data_oe), .load(load), .load_reads(load_reads), .load_err(load_err),
        .data(din), .ready_busy_n_output(rb_n), .resets_q(resets));
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // fail only when the recheck pair still toggles with error set
    function automatic result_t exp_result(input logic [7:0] r, input logic e);
        return (e && r >= 8'h03) ? RESULT_FAIL : RESULT_DONE;
    endfunction : exp_result
    // last status byte with both toggling bits masked; a fail rechecks after three finished reads
    function automatic logic [7:0] exp_status(input logic [7:0] r, input logic e);
        logic idle_bit;
        idle_bit = (exp_result(r, e) != RESULT_FAIL) || (r == 8'h03);
        return {idle_bit, 1'b0, e, 1'b0, !idle_bit, 3'b000};
    endfunction : exp_status
    task automatic set_device(input logic [7:0] r, input logic e);
        load_reads = r;
        load_err = e;
        load = 1;
        tick(1);
        load = 0;
        tick(2);
    endtask : set_device
    task automatic run_poll(input logic [7:0] r, input logic e);
        int i;
        logic [7:0] r0;
        r0 = resets;
        set_device(r, e);
        check(ready_seen, r == 8'h00);
        status_addr = 22'($urandom);
        start = 1;
        tick(1);
        start = 0;
        for (i = 0; i < 3000 && done !== 1'b1; i++) tick(1);
        if (i == 3000) begin
            n_errors++;
            final_report();
        end
        tick(2);
        check(result, exp_result(r, e));
        check(resets - r0, exp_result(r, e) == RESULT_FAIL);
        check(ready_seen, 1'b1);
        check(flash_addr, status_addr);
        check(last_status & 8'hBB, exp_status(r, e));
    endtask : run_poll
    initial begin
        void'($urandom(91));
        tick(12);
        reset_n = 1;
        run_poll(8'h00, 1'b0);
        run_poll(8'h01, 1'b1);
        run_poll(8'h02, 1'b1);
        run_poll(8'h03, 1'b1);
        run_poll(8'h28, 1'b1);
        run_poll(8'h28, 1'b0);
        repeat (8) run_poll(8'($urandom % 12), 1'($urandom));
        // abort in mid poll leaves the bus idle
        set_device(8'hC8, 1'b0);
        start = 1;
        tick(1);
        start = 0;
        tick(30);
        abort = 1;
        tick(1);
        abort = 0;
        tick(12);
        check(busy, 1'b0);
        check(cs_n, 1'b1);
        run_poll(8'h05, 1'b0);
        final_report();
    end
endmodule : test_flash_status_poller
`default_nettype wire
